// [hdl/flow_controller_regs.vh]
// constants for the flow controller holding-register bank
// assumes a 16-bit register request port fed by an external serial framing layer
`ifndef FLOW_CONTROLLER_REGS_VH
`define FLOW_CONTROLLER_REGS_VH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define ADDR_SETPOINT_PCT 16'h0000
`define ADDR_OVERRIDE 16'h0001
`define ADDR_COMMAND 16'h0002
`define ADDR_BLADE_PCT 16'h0004
`define ADDR_BLADE_DEG 16'h0005
`define ADDR_FLOW_PCT 16'h0006
`define ADDR_FLOW_UNITS 16'h0007
`define ADDR_ANALOG_MV 16'h0008
`define ADDR_SETPOINT_UNITS 16'h0014
`define ADDR_FIRMWARE 16'h0067
`define ADDR_STATUS 16'h0068
`define ADDR_MIN_LIMIT 16'h0069
`define ADDR_MAX_LIMIT 16'h006a
`define ADDR_FAIL_ACTION 16'h006c
`define ADDR_IF_MODE 16'h007a
`define ADDR_FLOW_UNIT_SEL 16'h00c9

// ----------------------------------------------------------------------------
// field values and limits
// ----------------------------------------------------------------------------
`define SCALE_FULL 16'h2710
`define OVR_NONE 16'h0000
`define OVR_MAX_CODE 16'h0004
`define CMD_NONE 16'h0000
`define CMD_ADAPT 16'h0001
`define CMD_TEST 16'h0002
`define CMD_RESET 16'h0004
`define FAIL_NOTHING 16'h0000
`define FAIL_CLOSE 16'h0001
`define FAIL_OPEN 16'h0002
`define FAIL_MIN 16'h0003
`define FAIL_MAX 16'h0005
`define UNIT_LPS 16'h0000
`define UNIT_M3H 16'h0001
`define UNIT_CFM 16'h0006
`define MODE_ANALOG 16'h0000
`define MODE_BUS_ANAFB 16'h0001
`define MODE_BUS_BUSFB 16'h0002
`define MODE_ANA_BUSFB 16'h0003
`define STAT_BIT_OVERLOAD 5
`define STAT_BIT_BUSY 8
`define STAT_BIT_TIMEOUT 10

// ----------------------------------------------------------------------------
// reset values (stored parameters come up at their factory defaults)
// ----------------------------------------------------------------------------
`define RST_ZERO 16'h0000
`define RST_MIN_LIMIT 16'h0000
`define RST_MAX_LIMIT 16'h2710
`define RST_FAIL_ACTION 16'h0000
`define RST_IF_MODE 16'h0002
`define RST_FLOW_UNIT 16'h0001
`define FIRMWARE_ID 16'h0101

`endif

// [hdl/flow_controller_modbus_regs.v]
// holding-register bank and setpoint-source selection for a flow damper controller
// assumes framing, crc and addressing are done outside; one request per cycle at most,
// actuator and analogue front end supply measured values as synchronous inputs
// no nonvolatile store is attached: stored limits and modes return to factory values
// after every reset, so a loader must rewrite them where the real values differ
//
// Notes on behaviour
// - interface mode preset at reset, changeable by menu or bus write.
// - analogue mode uses analogue setpoint; bus write to percent setpoint errors.
// - all other registers stay accessible in every interface mode.
// - override commands take effect even with analogue setpoint source.
// - mixed modes combine bus setpoint with analogue feedback, or reverse.
// - in bus operation actual values go to a register or analogue output.
// - percent setpoint, volatile read/write, 0 to 10000.
// - override selector: 0 none, 1 open, 2 close, 3 min, 4 max.
// - command trigger: 0 none, 1 adaptation, 2 test run, 4 reset.
// - read-only blade position, 0 to 10000 percent open.
// - read-only blade position in whole degrees.
// - actual flow as fraction of nominal, 0 to 10000.
// - read-only actual flow in unit chosen by unit selector.
// - read-only analogue input voltage in millivolts.
// - volatile setpoint in the selected physical flow unit.
// - status word: bit 5 overload, bit 8 busy, bit 10 bus timeout.
// - minimum flow limit, stored, 0 to 10000.
// - maximum flow limit, stored, 0 to 10000.
// - bus-failure action: 0 nothing, 1 close, 2 open, 3 min, 5 max.
// - unit selector: 0 litres/s, 1 cubic m/h, 6 cubic ft/min.
`timescale 1ns/10ps
`include "flow_controller_regs.vh"

module flow_controller_modbus_regs (
	input wire clk,
	input wire arst_n,
	input wire reqValid,
	input wire reqWrite,
	input wire [15:0] reqAddr,
	input wire [15:0] reqWData,
	output reg rspValid,
	output reg rspError,
	output reg [15:0] rspData,
	input wire menuModeValid,
	input wire [15:0] menuModeValue,
	input wire [15:0] bladePercent,
	input wire [15:0] bladeDegrees,
	input wire [15:0] flowPercent,
	input wire [15:0] flowUnits,
	input wire [15:0] analogMillivolts,
	input wire mechOverload,
	input wire internalBusy,
	input wire busTimeoutTripped,
	output reg [15:0] interfaceMode,
	output reg setpointFromAnalog,
	output reg feedbackOnAnalog,
	output reg [15:0] busSetpointPercent,
	output reg [15:0] busSetpointUnits,
	output reg [2:0] overrideSelect,
	output reg [15:0] minFlowLimit,
	output reg [15:0] maxFlowLimit,
	output reg [2:0] busFailAction,
	output reg [2:0] flowUnitSelect,
	output reg adaptStart,
	output reg testRunStart,
	output reg controllerReset
);

	// ------------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------------

	// kept apart from the read mux so the write path can refuse these early
	// read-only addresses: measured values, firmware id and status
	function isReadOnly;
		input [15:0] a;
		begin
			isReadOnly = (a == `ADDR_BLADE_PCT) || (a == `ADDR_BLADE_DEG) ||
				(a == `ADDR_FLOW_PCT) || (a == `ADDR_FLOW_UNITS) ||
				(a == `ADDR_ANALOG_MV) || (a == `ADDR_FIRMWARE) ||
				(a == `ADDR_STATUS);
		end
	endfunction

	// analogue setpoint source in modes 0 and 3; used for both outputs and write check
	function modeIsAnalogSetpoint;
		input [15:0] m;
		begin
			modeIsAnalogSetpoint = (m == `MODE_ANALOG) || (m == `MODE_ANA_BUSFB);
		end
	endfunction

	// legal interface mode codes, shared by menu and bus paths
	function modeLegal;
		input [15:0] m;
		begin
			modeLegal = (m <= `MODE_ANA_BUSFB);
		end
	endfunction

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	// bus-visible registers, current and next value
	reg [15:0] setpointPct_reg, setpointPct_next;
	reg [15:0] setpointUnits_reg, setpointUnits_next;
	reg [15:0] override_reg, override_next;
	reg [15:0] command_reg, command_next;
	reg [15:0] minLimit_reg, minLimit_next;
	reg [15:0] maxLimit_reg, maxLimit_next;
	reg [15:0] failAction_reg, failAction_next;
	reg [15:0] ifMode_reg, ifMode_next;
	reg [15:0] unitSel_reg, unitSel_next;
	// decode results shared by the read mux, the write checks and the answer
	reg cmdPulse_next;
	reg wrError, known;
	reg [15:0] readData;
	reg [15:0] statusWord;
	// request qualifiers; reqWrite means nothing while reqValid is low
	wire busWrite;
	wire busRead;

	assign busWrite = reqValid & reqWrite;
	assign busRead = reqValid & ~reqWrite;

	// ------------------------------------------------------------------------
	// status word assembly
	// ------------------------------------------------------------------------

	// only the three status flags; other bits read zero
	// levels are read live, so a read shows the flags of its taking cycle
	always @* begin
		statusWord = `RST_ZERO;
		statusWord[`STAT_BIT_OVERLOAD] = mechOverload;
		statusWord[`STAT_BIT_BUSY] = internalBusy;
		statusWord[`STAT_BIT_TIMEOUT] = busTimeoutTripped;
	end

	// ------------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------------

	// every register is readable whatever the interface mode
	// unmapped numbers leave known low, which the answer turns into an error
	always @* begin
		known = 1'b1;
		readData = `RST_ZERO;
		if (reqAddr == `ADDR_SETPOINT_PCT) begin
			readData = setpointPct_reg;
		end else if (reqAddr == `ADDR_OVERRIDE) begin
			readData = override_reg;
		end else if (reqAddr == `ADDR_COMMAND) begin
			readData = command_reg;
		end else if (reqAddr == `ADDR_BLADE_PCT) begin
			readData = bladePercent;
		end else if (reqAddr == `ADDR_BLADE_DEG) begin
			readData = bladeDegrees;
		end else if (reqAddr == `ADDR_FLOW_PCT) begin
			readData = flowPercent;
		end else if (reqAddr == `ADDR_FLOW_UNITS) begin
			readData = flowUnits;
		end else if (reqAddr == `ADDR_ANALOG_MV) begin
			readData = analogMillivolts;
		end else if (reqAddr == `ADDR_SETPOINT_UNITS) begin
			readData = setpointUnits_reg;
		end else if (reqAddr == `ADDR_FIRMWARE) begin
			readData = `FIRMWARE_ID;
		end else if (reqAddr == `ADDR_STATUS) begin
			readData = statusWord;
		end else if (reqAddr == `ADDR_MIN_LIMIT) begin
			readData = minLimit_reg;
		end else if (reqAddr == `ADDR_MAX_LIMIT) begin
			readData = maxLimit_reg;
		end else if (reqAddr == `ADDR_FAIL_ACTION) begin
			readData = failAction_reg;
		end else if (reqAddr == `ADDR_IF_MODE) begin
			readData = ifMode_reg;
		end else if (reqAddr == `ADDR_FLOW_UNIT_SEL) begin
			readData = unitSel_reg;
		end else begin
			known = 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// write decode and value checks
	// ------------------------------------------------------------------------

	// a rejected write changes nothing; out-of-range values are refused too,
	// since a stray code would drive the actuator into an undefined action
	always @* begin
		setpointPct_next = setpointPct_reg;
		setpointUnits_next = setpointUnits_reg;
		override_next = override_reg;
		command_next = command_reg;
		minLimit_next = minLimit_reg;
		maxLimit_next = maxLimit_reg;
		failAction_next = failAction_reg;
		ifMode_next = ifMode_reg;
		unitSel_next = unitSel_reg;
		cmdPulse_next = 1'b0;
		wrError = 1'b0;
		// local menu changes the mode; a bus write to the mode in the same cycle
		// is decoded further down and so wins
		if (menuModeValid && modeLegal(menuModeValue)) begin
			ifMode_next = menuModeValue;
		end
		if (busWrite) begin
			if (!known) begin
				wrError = 1'b1;
			end else if (isReadOnly(reqAddr)) begin
				wrError = 1'b1;
			end else if (reqAddr == `ADDR_SETPOINT_PCT) begin
				// in modes 0 and 3 the analogue input owns the setpoint
				if (modeIsAnalogSetpoint(ifMode_reg)) begin
					wrError = 1'b1;
				end else if (reqWData > `SCALE_FULL) begin
					wrError = 1'b1;
				end else begin
					setpointPct_next = reqWData;
				end
			end else if (reqAddr == `ADDR_OVERRIDE) begin
				// accepted in every mode, analogue included
				if (reqWData > `OVR_MAX_CODE) begin
					wrError = 1'b1;
				end else begin
					override_next = reqWData;
				end
			end else if (reqAddr == `ADDR_COMMAND) begin
				// the value stays for read-back; only the pulse starts an action
				if (reqWData == `CMD_NONE || reqWData == `CMD_ADAPT ||
					reqWData == `CMD_TEST || reqWData == `CMD_RESET) begin
					command_next = reqWData;
					cmdPulse_next = 1'b1;
				end else begin
					wrError = 1'b1;
				end
			end else if (reqAddr == `ADDR_SETPOINT_UNITS) begin
				setpointUnits_next = reqWData;
			end else if (reqAddr == `ADDR_MIN_LIMIT) begin
				// stored parameters: not meant for cyclic rewriting by the master
				if (reqWData > `SCALE_FULL) begin
					wrError = 1'b1;
				end else begin
					minLimit_next = reqWData;
				end
			end else if (reqAddr == `ADDR_MAX_LIMIT) begin
				if (reqWData > `SCALE_FULL) begin
					wrError = 1'b1;
				end else begin
					maxLimit_next = reqWData;
				end
			end else if (reqAddr == `ADDR_FAIL_ACTION) begin
				if (reqWData == `FAIL_NOTHING || reqWData == `FAIL_CLOSE ||
					reqWData == `FAIL_OPEN || reqWData == `FAIL_MIN ||
					reqWData == `FAIL_MAX) begin
					failAction_next = reqWData;
				end else begin
					wrError = 1'b1;
				end
			end else if (reqAddr == `ADDR_IF_MODE) begin
				if (modeLegal(reqWData)) begin
					ifMode_next = reqWData;
				end else begin
					wrError = 1'b1;
				end
			end else begin
				// only the unit selector is left
				if (reqWData == `UNIT_LPS || reqWData == `UNIT_M3H ||
					reqWData == `UNIT_CFM) begin
					unitSel_next = reqWData;
				end else begin
					wrError = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// register update
	// ------------------------------------------------------------------------

	// stored parameters reset to factory values; the bank has no memory interface
	// one flat bank keeps every write a single-cycle update, at the cost of area
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			setpointPct_reg <= `RST_ZERO;
			setpointUnits_reg <= `RST_ZERO;
			override_reg <= `RST_ZERO;
			command_reg <= `RST_ZERO;
			minLimit_reg <= `RST_MIN_LIMIT;
			maxLimit_reg <= `RST_MAX_LIMIT;
			failAction_reg <= `RST_FAIL_ACTION;
			ifMode_reg <= `RST_IF_MODE;
			unitSel_reg <= `RST_FLOW_UNIT;
		end else begin
			setpointPct_reg <= setpointPct_next;
			setpointUnits_reg <= setpointUnits_next;
			override_reg <= override_next;
			command_reg <= command_next;
			minLimit_reg <= minLimit_next;
			maxLimit_reg <= maxLimit_next;
			failAction_reg <= failAction_next;
			ifMode_reg <= ifMode_next;
			unitSel_reg <= unitSel_next;
		end
	end

	// ------------------------------------------------------------------------
	// answer to the framing layer
	// ------------------------------------------------------------------------

	// one answer per request, the cycle after it; reads of unmapped addresses error
	// an accepted write echoes its data so the framing layer can build the reply
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rspValid <= 1'b0;
			rspError <= 1'b0;
			rspData <= `RST_ZERO;
		end else begin
			rspValid <= reqValid;
			rspError <= (busRead & ~known) | (busWrite & wrError);
			if (busRead && known) begin
				rspData <= readData;
			end else if (busWrite && !wrError) begin
				rspData <= reqWData;
			end else begin
				rspData <= `RST_ZERO;
			end
		end
	end

	// ------------------------------------------------------------------------
	// outputs to the control loop
	// ------------------------------------------------------------------------

	// outputs other than the command pulses follow the register values one cycle later, straight from flops
	// mode flags are registered with the mode, so all three change together
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			interfaceMode <= `RST_IF_MODE;
			setpointFromAnalog <= 1'b0;
			feedbackOnAnalog <= 1'b0;
			busSetpointPercent <= `RST_ZERO;
			busSetpointUnits <= `RST_ZERO;
			overrideSelect <= 3'b000;
			minFlowLimit <= `RST_MIN_LIMIT;
			maxFlowLimit <= `RST_MAX_LIMIT;
			busFailAction <= 3'b000;
			flowUnitSelect <= 3'b001;
			adaptStart <= 1'b0;
			testRunStart <= 1'b0;
			controllerReset <= 1'b0;
		end else begin
			interfaceMode <= ifMode_reg;
			setpointFromAnalog <= modeIsAnalogSetpoint(ifMode_reg);
			// modes 0 and 1 report actual values on the analogue output
			feedbackOnAnalog <= (ifMode_reg == `MODE_ANALOG) ||
				(ifMode_reg == `MODE_BUS_ANAFB);
			busSetpointPercent <= setpointPct_reg;
			busSetpointUnits <= setpointUnits_reg;
			// only low bits leave; the write checks already bound every code
			overrideSelect <= override_reg[2:0];
			minFlowLimit <= minLimit_reg;
			maxFlowLimit <= maxLimit_reg;
			busFailAction <= failAction_reg[2:0];
			flowUnitSelect <= unitSel_reg[2:0];
			// commands start on the accepted write, one pulse each
			adaptStart <= cmdPulse_next && (reqWData == `CMD_ADAPT);
			testRunStart <= cmdPulse_next && (reqWData == `CMD_TEST);
			controllerReset <= cmdPulse_next && (reqWData == `CMD_RESET);
		end
	end

endmodule

// [testbench/flow_controller_modbus_regs_properties.sv]
// concurrent checks on the holding-register bank ports
// assumes one request per cycle at most and the answer one cycle after it is taken
`timescale 1ns/10ps
module flow_controller_modbus_regs_properties (
	input wire clk,
	input wire arst_n,
	input wire reqValid,
	input wire reqWrite,
	input wire [15:0] reqAddr,
	input wire [15:0] reqWData,
	input wire rspValid,
	input wire rspError,
	input wire [15:0] rspData,
	input wire menuModeValid,
	input wire [15:0] bladePercent,
	input wire mechOverload,
	input wire internalBusy,
	input wire busTimeoutTripped,
	input wire [15:0] interfaceMode,
	input wire setpointFromAnalog,
	input wire feedbackOnAnalog,
	input wire [2:0] overrideSelect,
	input wire adaptStart,
	input wire testRunStart
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ------------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------------
	wire isWrite = reqValid && reqWrite;
	wire isRead = reqValid && !reqWrite;
	wire roAddr = (reqAddr >= 16'h0004 && reqAddr <= 16'h0008) || reqAddr == 16'h0067 ||
		reqAddr == 16'h0068;
	chk_rsp_latency: assert property (reqValid |=> rspValid) else $error("answer missing");
	chk_rsp_idle: assert property (!reqValid |=> !rspValid) else $error("answer without request");
	chk_ro_refused: assert property (isWrite && roAddr |=> rspValid && rspError)
		else $error("read-only write accepted");
	// the mode outputs lag one cycle, so a mode change just before is left out
	chk_analog_sp_refused: assert property (isWrite && reqAddr == 16'h0000 && setpointFromAnalog
		&& !$past(menuModeValid) && !$past(isWrite) |=> rspError) else $error("setpoint taken");
	chk_status_live: assert property (isRead && reqAddr == 16'h0068 |=> !rspError &&
		rspData == {5'h00, $past(busTimeoutTripped), 1'b0, $past(internalBusy), 2'b00,
		$past(mechOverload), 5'h00}) else $error("status word wrong");
	chk_blade_read: assert property (isRead && reqAddr == 16'h0004 |=>
		rspData == $past(bladePercent)) else $error("blade position wrong");
	chk_test_pulse: assert property (isWrite && reqAddr == 16'h0002 && reqWData == 16'h0002
		|=> testRunStart && !adaptStart) else $error("test run not started");
	chk_adapt_cause: assert property ($rose(adaptStart) |->
		$past(isWrite && reqAddr == 16'h0002 && reqWData == 16'h0001)) else $error("stray adapt");
	chk_override_apply: assert property (isWrite && reqAddr == 16'h0001 && reqWData <= 16'h0004
		|=> ##1 overrideSelect == $past(reqWData[2:0], 2)) else $error("override not applied");
	chk_limit_range: assert property (isWrite && (reqAddr == 16'h0069 || reqAddr == 16'h006a)
		&& reqWData > 16'h2710 |=> rspError) else $error("limit over range taken");
	chk_mode_decode: assert property (setpointFromAnalog == (interfaceMode == 16'h0000 ||
		interfaceMode == 16'h0003) && feedbackOnAnalog == (interfaceMode <= 16'h0001))
		else $error("mode decode wrong");
	cover property (isWrite && reqAddr == 16'h0000 && setpointFromAnalog);
	cover property (testRunStart);
	cover property (isRead && roAddr);
endmodule
bind flow_controller_modbus_regs flow_controller_modbus_regs_properties chk_u (.clk(clk),
	.arst_n(arst_n), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
	.reqWData(reqWData), .rspValid(rspValid), .rspError(rspError), .rspData(rspData),
	.menuModeValid(menuModeValid), .bladePercent(bladePercent), .mechOverload(mechOverload),
	.internalBusy(internalBusy), .busTimeoutTripped(busTimeoutTripped),
	.interfaceMode(interfaceMode), .setpointFromAnalog(setpointFromAnalog),
	.feedbackOnAnalog(feedbackOnAnalog), .overrideSelect(overrideSelect),
	.adaptStart(adaptStart), .testRunStart(testRunStart));

// [testbench/bms_master_model.sv]
// building-management master issuing single register requests
// assumes the answer is registered on the taking edge and read just after it
`timescale 1ns/10ps
module bms_master_model (
	input wire clk,
	output logic reqValid,
	output logic reqWrite,
	output logic [15:0] reqAddr,
	output logic [15:0] reqWData,
	input wire rspError,
	input wire [15:0] rspData
);
	initial begin
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = 16'h0000;
		reqWData = 16'h0000;
	end
	// one request, held over its taking edge; address and data inverted afterwards so no stale value lingers
	task automatic xfer(input logic w, input logic [15:0] a, d, output logic e,
		output logic [15:0] q);
		@(posedge clk);
		#1;
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqWData = d;
		@(posedge clk);
		#1;
		e = rspError;
		q = rspData;
		reqValid = 1'b0;
		reqAddr = ~a;
		reqWData = ~d;
	endtask
endmodule

// [testbench/test_flow_controller_modbus_regs.sv]
// self-checking bench for the holding-register bank
// assumes the master model drives the request port and the bench drives measured inputs
`timescale 1ns/10ps
`include "flow_controller_regs.vh"
module test_flow_controller_modbus_regs;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic reqValid, reqWrite, rspValid, rspError, setpointFromAnalog, feedbackOnAnalog;
	logic adaptStart, testRunStart, controllerReset;
	logic menuModeValid = 1'b0, mechOverload = 1'b0, internalBusy = 1'b0;
	logic busTimeoutTripped = 1'b0;
	logic [15:0] menuModeValue = 16'h0000, bladePercent = 16'h0000, bladeDegrees = 16'h0000;
	logic [15:0] flowPercent = 16'h0000, flowUnits = 16'h0000, analogMillivolts = 16'h0000;
	logic [15:0] reqAddr, reqWData, rspData, interfaceMode, busSetpointPercent;
	logic [15:0] busSetpointUnits, minFlowLimit, maxFlowLimit, a, d;
	logic [2:0] overrideSelect, busFailAction, flowUnitSelect;
	logic [15:0] sh [0:255];
	logic [15:0] rwList [0:8] = '{16'h0000, 16'h0001, 16'h0014, 16'h0069, 16'h006a, 16'h006c,
		16'h007a, 16'h00c9, 16'h0002};
	logic [15:0] roList [0:6] = '{16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0067,
		16'h0068};
	int error_cnt = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	flow_controller_modbus_regs dut_u (.clk(clk), .arst_n(arst_n), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqWData(reqWData), .rspValid(rspValid),
		.rspError(rspError), .rspData(rspData), .menuModeValid(menuModeValid),
		.menuModeValue(menuModeValue), .bladePercent(bladePercent), .bladeDegrees(bladeDegrees),
		.flowPercent(flowPercent), .flowUnits(flowUnits), .analogMillivolts(analogMillivolts),
		.mechOverload(mechOverload), .internalBusy(internalBusy),
		.busTimeoutTripped(busTimeoutTripped), .interfaceMode(interfaceMode),
		.setpointFromAnalog(setpointFromAnalog), .feedbackOnAnalog(feedbackOnAnalog),
		.busSetpointPercent(busSetpointPercent), .busSetpointUnits(busSetpointUnits),
		.overrideSelect(overrideSelect), .minFlowLimit(minFlowLimit), .maxFlowLimit(maxFlowLimit),
		.busFailAction(busFailAction), .flowUnitSelect(flowUnitSelect), .adaptStart(adaptStart),
		.testRunStart(testRunStart), .controllerReset(controllerReset));
	bms_master_model master_u (.clk(clk), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqWData(reqWData), .rspError(rspError), .rspData(rspData));
	// ------------------------------------------------------------------
	// expectation helpers
	// ------------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	// value ranges per register; unmapped and read-only places are never legal to write
	function automatic logic legal(input logic [15:0] a, d, m);
		case (a)
		16'h0000: legal = (m == 16'h0001 || m == 16'h0002) && d <= 16'h2710;
		16'h0001: legal = d <= 16'h0004;
		16'h0002: legal = d == 16'h0000 || d == 16'h0001 || d == 16'h0002 || d == 16'h0004;
		16'h0014: legal = 1'b1;
		16'h0069, 16'h006a: legal = d <= 16'h2710;
		16'h006c: legal = d <= 16'h0003 || d == 16'h0005;
		16'h007a: legal = d <= 16'h0003;
		16'h00c9: legal = d == 16'h0000 || d == 16'h0001 || d == 16'h0006;
		default: legal = 1'b0;
		endcase
	endfunction
	function automatic logic [15:0] meas(input logic [15:0] a);
		case (a)
		16'h0004: meas = bladePercent;
		16'h0005: meas = bladeDegrees;
		16'h0006: meas = flowPercent;
		16'h0007: meas = flowUnits;
		16'h0008: meas = analogMillivolts;
		16'h0068: meas = {5'h00, busTimeoutTripped, 1'b0, internalBusy, 2'b00, mechOverload, 5'h00};
		default: meas = `FIRMWARE_ID;
		endcase
	endfunction
	task automatic acc(input logic w, input logic [15:0] a, d, input logic eErr,
		input logic [15:0] eData);
		logic e;
		logic [15:0] q;
		master_u.xfer(w, a, d, e, q);
		chk("rspError", {15'h0000, eErr}, {15'h0000, e});
		chk("rspData", eData, q);
	endtask
	// a refused write must leave the shadow untouched and answer zero data
	task automatic wr(input logic [15:0] a, d);
		logic ok;
		ok = legal(a, d, sh[8'h7a]);
		acc(1'b1, a, d, !ok, ok ? d : 16'h0000);
		if (ok)
			sh[a[7:0]] = d;
	endtask
	task automatic outs;
		// the outputs trail the registers by one edge
		@(posedge clk);
		#1;
		chk("busSetpointPercent", sh[8'h00], busSetpointPercent);
		chk("busSetpointUnits", sh[8'h14], busSetpointUnits);
		chk("overrideSelect", {13'h0000, sh[8'h01][2:0]}, {13'h0000, overrideSelect});
		chk("minFlowLimit", sh[8'h69], minFlowLimit);
		chk("maxFlowLimit", sh[8'h6a], maxFlowLimit);
		chk("busFailAction", {13'h0000, sh[8'h6c][2:0]}, {13'h0000, busFailAction});
		chk("flowUnitSelect", {13'h0000, sh[8'hc9][2:0]}, {13'h0000, flowUnitSelect});
		chk("interfaceMode", sh[8'h7a], interfaceMode);
	endtask
	// shadow copy of the register bank at its reset values
	task shadow_init;
		foreach (sh[i])
			sh[i] = 16'h0000;
		sh[8'h6a] = 16'h2710;
		sh[8'h7a] = 16'h0002;
		sh[8'hc9] = 16'h0001;
	endtask
	task close_out;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#2000000;
		error_cnt++;
		close_out();
	end
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(40681));
		shadow_init();
		repeat (16) @(posedge clk);
		#1;
		arst_n = 1'b1;
		foreach (rwList[i])
			acc(1'b0, rwList[i], 16'h0000, 1'b0, sh[rwList[i][7:0]]);
		wr(16'h0069, 16'h2710);
		wr(16'h006a, 16'h2711);
		repeat (300) begin
			a = rwList[$urandom_range(0, 8)];
			d = $urandom_range(0, 1) ? 16'($urandom_range(0, 7)) : 16'($urandom_range(0, 16'h2800));
			wr(a, d);
			acc(1'b0, a, 16'h0000, 1'b0, sh[a[7:0]]);
		end
		outs();
		repeat (20) begin
			{bladePercent, bladeDegrees, flowPercent} = {$urandom, $urandom};
			{flowUnits, analogMillivolts} = $urandom;
			{mechOverload, internalBusy, busTimeoutTripped} = 3'($urandom);
			foreach (roList[i]) begin
				wr(roList[i], 16'($urandom));
				acc(1'b0, roList[i], 16'h0000, 1'b0, meas(roList[i]));
			end
		end
		acc(1'b0, 16'h0003, 16'h0000, 1'b1, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			#1;
			menuModeValid = 1'b1;
			menuModeValue = 16'(m);
			@(posedge clk);
			#1;
			menuModeValid = 1'b0;
			sh[8'h7a] = 16'(m);
			@(posedge clk);
			#1;
			chk("modeOuts", {14'h0000, m == 0 || m == 3, m <= 1},
				{14'h0000, setpointFromAnalog, feedbackOnAnalog});
			wr(16'h0000, 16'h1388);
			wr(16'h0001, 16'(m + 1));
			outs();
		end
		foreach (rwList[i])
			if (i < 3) begin
				d = 16'h0001 << i;
				wr(16'h0002, d);
				chk("cmdPulse", {13'h0000, d[2:0]},
					{13'h0000, controllerReset, testRunStart, adaptStart});
			end
		// reset in mid-run: every register, the outputs checked by outs and the three command pulses back at their reset values
		arst_n = 1'b0;
		shadow_init();
		repeat (4) @(posedge clk);
		#1;
		arst_n = 1'b1;
		outs();
		chk("cmdPulse", 16'h0000, {13'h0000, controllerReset, testRunStart, adaptStart});
		foreach (rwList[i])
			acc(1'b0, rwList[i], 16'h0000, 1'b0, sh[rwList[i][7:0]]);
		close_out();
	end
endmodule
